//--- hw/cip_counter_interrupt.sv
// counter stepping and program interrupt priority between instructions
// Overview of operation
// RL1: an oscillator divider chain steps the time counters every 312 us.
// RL2: program timer counters raise an interrupt when they overflow.
// RL3: every external step request is latched and held until serviced.
// RL4: at an instruction end with nothing pending the next starts at once.
// RL5: a counter service is one read-modify-write cycle at its own word.
// RL6: all pending counter services run back to back before the next fetch.
// RL7: an overflow of one counter becomes a step request of another.
// RL8: the steps are add one, add minus one, reduce magnitude, shift in 0 or 1.
// RL9: encoder counters step up or down modulo two to the fifteenth.
// RL10: an interrupt is taken between instructions and jumps to a per-source vector.
// RL11: interrupt entry takes three memory cycles saving pc and next buffer.
// RL12: no interrupt nests; requests wait until the resume.
// RL13: simultaneous requests are served in fixed low-index-first order.
// RL14: counter services go before a pending interrupt.
`timescale 1ns/1ns
module cip_counter_interrupt (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic oscPin,
  input wire logic [cip_pkg::CNT_NUM-1:0] countUpPin,
  input wire logic [cip_pkg::CNT_NUM-1:0] countDownPin,
  input wire logic [cip_pkg::PIN_IRQ_NUM-1:0] irqPin,
  input wire cip_pkg::cip_seq_in_s seqIn,
  input wire cip_pkg::cip_prog_req_s progReq,
  output cip_pkg::cip_seq_out_s seqOut,
  output logic [cip_pkg::WORD_W-1:0] progRdata
);
  cip_pkg::cip_regs_s r;
  cip_pkg::cip_regs_s next_r;
  logic memRd;
  logic memWr;
  logic [cip_pkg::CNT_AW-1:0] memAddr;
  logic [cip_pkg::WORD_W-1:0] memWdata;
  logic [cip_pkg::WORD_W-1:0] memRdata;
  logic nextGo;
  logic tick;
  logic oscRise;
  logic [cip_pkg::CNT_NUM-1:0] upRise;
  logic [cip_pkg::CNT_NUM-1:0] dnRise;
  logic [cip_pkg::PIN_IRQ_NUM-1:0] rpRise;
  logic [cip_pkg::PEND_W-1:0] pendSet;
  logic [cip_pkg::PEND_W-1:0] pendClr;
  logic [cip_pkg::PEND_W-1:0] cntAll;
  logic [cip_pkg::IRQ_NUM-1:0] irqSet;
  logic [cip_pkg::IRQ_NUM-1:0] irqClr;
  logic [cip_pkg::IRQ_NUM-1:0] irqAll;
  logic [cip_pkg::IRQ_IW-1:0] irqFirst;
  logic activeAfter;
  logic takeIrq;
  logic boundary;
  logic [cip_pkg::CNT_AW-1:0] srvCtr;
  logic srvDown;
  cip_pkg::cip_kind_e srvKind;
  cip_pkg::cip_op_e srvOp;
  logic [cip_pkg::WORD_W-1:0] srvResult;
  logic ovfPlus;

  function automatic logic [cip_pkg::PEND_IW-1:0] firstPend(
    input logic [cip_pkg::PEND_W-1:0] pend
  );
    logic [cip_pkg::PEND_IW-1:0] idx;
    idx = '0;
    for (int i = cip_pkg::PEND_W - 1; i >= 0; i--) begin
      if (pend[i]) begin
        idx = cip_pkg::PEND_IW'(i);
      end
    end
    return idx;
  endfunction : firstPend

  function automatic logic [cip_pkg::IRQ_IW-1:0] firstIrq(
    input logic [cip_pkg::IRQ_NUM-1:0] pend
  );
    logic [cip_pkg::IRQ_IW-1:0] idx;
    idx = '0;
    for (int i = cip_pkg::IRQ_NUM - 1; i >= 0; i--) begin
      if (pend[i]) begin
        idx = cip_pkg::IRQ_IW'(i);
      end
    end
    return idx;
  endfunction : firstIrq

  cip_word_mem u_mem (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .rdEn(memRd),
    .wrEn(memWr),
    .addr(memAddr),
    .wdata(memWdata),
    .rdata(memRdata)
  );

  // step arithmetic on the word read in the first half of the cycle
  always_comb begin
    srvCtr = r.srvSel[cip_pkg::CNT_AW-1:0];
    srvDown = r.srvSel[cip_pkg::PEND_IW-1];
    srvKind = cip_pkg::cip_kind_e'(cip_pkg::CNT_KIND_MAP[{srvCtr, 1'b0} +: 2]);
    case (srvKind)
      cip_pkg::KIND_ONES: srvOp = srvDown ? cip_pkg::OP_MINUS : cip_pkg::OP_PLUS;
      cip_pkg::KIND_DIM: srvOp = cip_pkg::OP_DIM;
      cip_pkg::KIND_SHIFT: srvOp = srvDown ? cip_pkg::OP_SHIFT0 : cip_pkg::OP_SHIFT1;
      default: srvOp = srvDown ? cip_pkg::OP_ENC_MINUS : cip_pkg::OP_ENC_PLUS;
    endcase
    ovfPlus = 1'b0;
    case (srvOp)
      cip_pkg::OP_PLUS: begin // [RL8]
        if (memRdata == cip_pkg::POS_MAX) begin
          srvResult = cip_pkg::POS_ZERO;
          ovfPlus = 1'b1;
        end else if (memRdata == cip_pkg::NEG_ZERO) begin
          srvResult = cip_pkg::POS_ONE;
        end else begin
          srvResult = memRdata + 15'h0001;
        end
      end
      cip_pkg::OP_MINUS: begin // [RL8]
        if (memRdata == cip_pkg::NEG_MAX) begin
          srvResult = cip_pkg::NEG_ZERO;
        end else if (memRdata == cip_pkg::POS_ZERO) begin
          srvResult = cip_pkg::NEG_ONE;
        end else begin
          srvResult = memRdata - 15'h0001;
        end
      end
      cip_pkg::OP_DIM: begin // [RL8]
        if (memRdata == cip_pkg::POS_ZERO || memRdata == cip_pkg::NEG_ZERO) begin
          srvResult = memRdata;
        end else if (memRdata[cip_pkg::WORD_W-1]) begin
          srvResult = memRdata + 15'h0001;
        end else begin
          srvResult = memRdata - 15'h0001;
        end
      end
      cip_pkg::OP_SHIFT0: srvResult = {memRdata[cip_pkg::WORD_W-2:0], 1'b0}; // [RL8]
      cip_pkg::OP_SHIFT1: srvResult = {memRdata[cip_pkg::WORD_W-2:0], 1'b1}; // [RL8]
      // plain binary wrap, no end-around carry
      cip_pkg::OP_ENC_PLUS: srvResult = memRdata + 15'h0001; // [RL9]
      cip_pkg::OP_ENC_MINUS: srvResult = memRdata - 15'h0001; // [RL9]
      default: srvResult = memRdata;
    endcase
  end

  always_comb begin
    next_r = r;
    next_r.entryValid = 1'b0;
    nextGo = 1'b0;
    memRd = 1'b0;
    memWr = 1'b0;
    memAddr = progReq.addr;
    memWdata = progReq.wdata;
    tick = 1'b0;
    // pins pass two flops; edges are seen on the second stage only
    next_r.oscS1 = oscPin;
    next_r.oscS2 = r.oscS1;
    next_r.oscPrev = r.oscS2;
    next_r.upS1 = countUpPin;
    next_r.upS2 = r.upS1;
    next_r.upPrev = r.upS2;
    next_r.dnS1 = countDownPin;
    next_r.dnS2 = r.dnS1;
    next_r.dnPrev = r.dnS2;
    next_r.rpS1 = irqPin;
    next_r.rpS2 = r.rpS1;
    next_r.rpPrev = r.rpS2;
    oscRise = r.oscS2 & ~r.oscPrev;
    upRise = r.upS2 & ~r.upPrev;
    dnRise = r.dnS2 & ~r.dnPrev;
    rpRise = r.rpS2 & ~r.rpPrev;
    if (oscRise) begin // [RL1]
      if (r.divCount == cip_pkg::DIV_LAST) begin
        next_r.divCount = '0;
        tick = 1'b1;
      end else begin
        next_r.divCount = r.divCount + 10'h001;
      end
    end
    // set beats clear so a request arriving during its own service survives
    pendSet = {dnRise, upRise}; // [RL3]
    if (tick) begin
      pendSet[cip_pkg::TIME_LOW_CTR] = 1'b1; // [RL1]
    end
    if (r.state == cip_pkg::ST_CNT_WR && ovfPlus && cip_pkg::CHAIN_MAP[srvCtr]) begin
      pendSet[{1'b0, srvCtr} + 4'h1] = 1'b1; // [RL7]
    end
    pendClr = '0;
    if (r.state == cip_pkg::ST_CNT_WR) begin
      pendClr[r.srvSel] = 1'b1; // [RL3]
    end
    cntAll = (r.cntPend & ~pendClr) | pendSet;
    irqSet = '0;
    irqSet[cip_pkg::PIN_IRQ_BASE +: cip_pkg::PIN_IRQ_NUM] = rpRise;
    if (r.state == cip_pkg::ST_CNT_WR && ovfPlus && cip_pkg::TIMER_MAP[srvCtr]) begin
      irqSet[cip_pkg::IRQ_IW'(srvCtr - cip_pkg::TIMER_CTR_BASE)] = 1'b1; // [RL2]
    end
    irqAll = r.irqPend | irqSet;
    irqFirst = firstIrq(irqAll); // [RL13]
    activeAfter = r.irqActive & ~seqIn.resumeDone;
    takeIrq = (|irqAll) & ~activeAfter & ~seqIn.irqInhibit; // [RL12]
    boundary = (r.state == cip_pkg::ST_RUN && seqIn.instrDone)
      || r.state == cip_pkg::ST_CNT_WR;
    irqClr = '0;
    next_r.irqActive = activeAfter;
    case (r.state)
      cip_pkg::ST_RUN: begin
        memRd = progReq.rd;
        memWr = progReq.wr;
      end
      cip_pkg::ST_CNT_RD: begin
        memRd = 1'b1; // [RL5]
        memAddr = srvCtr;
        next_r.state = cip_pkg::ST_CNT_WR;
      end
      cip_pkg::ST_CNT_WR: begin
        memWr = 1'b1; // [RL5]
        memAddr = srvCtr;
        memWdata = srvResult;
      end
      cip_pkg::ST_ENTRY: begin
        next_r.phase = r.phase + 3'h1;
        if (r.phase == cip_pkg::PH_PC) begin
          next_r.savedPc = seqIn.pc; // [RL11]
        end
        if (r.phase == cip_pkg::PH_BUF) begin
          next_r.savedBuf = seqIn.nextBuf; // [RL11]
        end
        if (r.phase == cip_pkg::PH_VEC) begin
          // one vector per source
          next_r.vectorPc = cip_pkg::IRQ_VEC_BASE
            + cip_pkg::PC_W'(r.irqSel) * cip_pkg::IRQ_VEC_STRIDE; // [RL10]
          next_r.entryValid = 1'b1;
        end
        if (r.phase == cip_pkg::PH_JUMP) begin
          nextGo = 1'b1; // [RL11]
          next_r.state = cip_pkg::ST_RUN;
        end
      end
      default: next_r.state = cip_pkg::ST_RUN;
    endcase
    if (boundary) begin
      if (|cntAll) begin
        // counters first; costs program time in step with counter load
        next_r.state = cip_pkg::ST_CNT_RD; // [RL6] [RL14]
        next_r.srvSel = firstPend(cntAll); // [RL13]
      end else if (takeIrq) begin
        next_r.state = cip_pkg::ST_ENTRY; // [RL10]
        next_r.phase = '0;
        next_r.irqSel = irqFirst;
        next_r.irqActive = 1'b1; // [RL12]
        irqClr[irqFirst] = 1'b1;
      end else begin
        nextGo = 1'b1; // [RL4]
        next_r.state = cip_pkg::ST_RUN;
      end
    end
    next_r.cntPend = cntAll;
    next_r.irqPend = (r.irqPend & ~irqClr) | irqSet;
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= cip_pkg::REGS_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign seqOut.nextGo = nextGo;
  assign seqOut.busy = (r.state != cip_pkg::ST_RUN);
  assign seqOut.entryValid = r.entryValid;
  assign seqOut.vectorPc = r.vectorPc;
  assign seqOut.savedPc = r.savedPc;
  assign seqOut.savedBuf = r.savedBuf;
  assign progRdata = memRdata;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  direct_next_a: assert property ( // [RL4]
    (r.state == cip_pkg::ST_RUN && seqIn.instrDone && r.cntPend == '0
      && !takeIrq && pendSet == '0) |-> nextGo)
    else $error("next instruction delayed with nothing pending");

  one_cycle_service_a: assert property ( // [RL5]
    r.state == cip_pkg::ST_CNT_RD |=> r.state == cip_pkg::ST_CNT_WR
      && memWr && memAddr == $past(memAddr))
    else $error("counter service is not a read then write of one word");

  back_to_back_a: assert property ( // [RL6]
    (r.state == cip_pkg::ST_CNT_WR && cntAll != '0) |=> r.state == cip_pkg::ST_CNT_RD)
    else $error("pending counter not serviced back to back");

  tick_request_a: assert property ( // [RL1]
    tick |=> r.cntPend[cip_pkg::TIME_LOW_CTR])
    else $error("time quantum did not request a time step");

  pend_hold_a: assert property ( // [RL3]
    $fell(r.cntPend[0]) |-> $past(r.state) == cip_pkg::ST_CNT_WR && $past(r.srvSel) == '0)
    else $error("counter request dropped without service");

  chain_step_a: assert property ( // [RL7]
    (r.state == cip_pkg::ST_CNT_WR && r.srvSel == '0 && ovfPlus) |=> r.cntPend[1])
    else $error("time overflow did not step the high counter");

  timer_irq_a: assert property ( // [RL2]
    (r.state == cip_pkg::ST_CNT_WR && r.srvSel == 4'h2 && ovfPlus) |=> r.irqPend[0]
      || r.state == cip_pkg::ST_ENTRY)
    else $error("timer overflow raised no interrupt");

  priority_order_a: assert property ( // [RL13]
    r.state == cip_pkg::ST_CNT_RD |-> ($past(cntAll) & ((16'h0001 << r.srvSel) - 16'h0001)) == '0)
    else $error("lower index request skipped");

  encoder_wrap_a: assert property ( // [RL9]
    (r.state == cip_pkg::ST_CNT_WR && srvOp == cip_pkg::OP_ENC_PLUS)
      |-> memWdata == 15'(memRdata + 15'h0001))
    else $error("encoder step not modulo two to the fifteenth");

  shift_one_a: assert property ( // [RL8]
    (r.state == cip_pkg::ST_CNT_WR && srvOp == cip_pkg::OP_SHIFT1)
      |-> memWdata == {memRdata[13:0], 1'b1})
    else $error("shift in one wrong");

  entry_length_a: assert property ( // [RL11]
    (r.state != cip_pkg::ST_ENTRY ##1 r.state == cip_pkg::ST_ENTRY)
      |-> ##5 (nextGo && r.entryValid))
    else $error("interrupt entry not three memory cycles");

  no_nesting_a: assert property ( // [RL12]
    (r.state != cip_pkg::ST_ENTRY && next_r.state == cip_pkg::ST_ENTRY) |-> !activeAfter)
    else $error("interrupt taken inside an interrupt");

  counters_first_a: assert property ( // [RL14]
    (r.state != cip_pkg::ST_ENTRY && next_r.state == cip_pkg::ST_ENTRY) |-> cntAll == '0)
    else $error("interrupt taken with counters pending");

  vector_fixed_a: assert property ( // [RL10]
    r.entryValid |-> r.vectorPc == cip_pkg::IRQ_VEC_BASE
      + cip_pkg::PC_W'(r.irqSel) * cip_pkg::IRQ_VEC_STRIDE)
    else $error("interrupt vector not the source location");
endmodule : cip_counter_interrupt

//--- hw/cip_pkg.sv
// constants, tables and types of the counter and interrupt priority block
package cip_pkg;
  localparam int WORD_W = 15;
  localparam int CNT_NUM = 8;
  localparam int CNT_AW = 3;
  localparam int PEND_W = 2 * CNT_NUM;
  localparam int PEND_IW = 4;
  localparam int IRQ_NUM = 4;
  localparam int IRQ_IW = 2;
  localparam int PIN_IRQ_NUM = 2;
  localparam int PC_W = 12;

  // real-time base: oscillator edges per time quantum
  localparam int OSC_KHZ = 2048;
  localparam int TIME_QUANTUM_NS = 312500;
  localparam int OSC_PER_TICK = OSC_KHZ * TIME_QUANTUM_NS / 1000000;
  localparam int DIV_W = 10;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(OSC_PER_TICK - 1);

  // one memory cycle is a read clock and a write clock
  localparam int MCT_CLKS = 2;
  localparam int ENTRY_MCT = 3;
  localparam int ENTRY_CLKS = ENTRY_MCT * MCT_CLKS;
  localparam logic [2:0] PH_PC = 3'(MCT_CLKS - 1);
  localparam logic [2:0] PH_BUF = 3'(2 * MCT_CLKS - 1);
  localparam logic [2:0] PH_VEC = 3'(ENTRY_CLKS - 2);
  localparam logic [2:0] PH_JUMP = 3'(ENTRY_CLKS - 1);

  // one's-complement landmarks
  localparam logic [WORD_W-1:0] POS_ZERO = 15'h0000;
  localparam logic [WORD_W-1:0] POS_ONE = 15'h0001;
  localparam logic [WORD_W-1:0] POS_MAX = 15'h3FFF;
  localparam logic [WORD_W-1:0] NEG_MAX = 15'h4000;
  localparam logic [WORD_W-1:0] NEG_ONE = 15'h7FFE;
  localparam logic [WORD_W-1:0] NEG_ZERO = 15'h7FFF;
  localparam logic [WORD_W-1:0] WORD_RESET = 15'h0000;

  typedef enum logic [1:0] {KIND_ONES, KIND_DIM, KIND_SHIFT, KIND_ENC} cip_kind_e;
  // two bits per counter, counter 0 in the low bits: 7,6 encoder, 5 shift, 4 dim, 3..0 ones
  localparam logic [2*CNT_NUM-1:0] CNT_KIND_MAP = 16'hF900;
  // counter 0 (time low) overflows into counter 1 (time high)
  localparam logic [CNT_NUM-1:0] CHAIN_MAP = 8'h01;
  localparam logic [CNT_AW-1:0] TIME_LOW_CTR = 3'h0;
  // counters 2 and 3 are program timers raising sources 0 and 1
  localparam logic [CNT_NUM-1:0] TIMER_MAP = 8'h0C;
  localparam logic [CNT_AW-1:0] TIMER_CTR_BASE = 3'h2;
  localparam logic [IRQ_IW-1:0] PIN_IRQ_BASE = 2'h2;
  localparam logic [PC_W-1:0] IRQ_VEC_BASE = 12'h400;
  localparam logic [PC_W-1:0] IRQ_VEC_STRIDE = 12'h004;

  typedef enum logic [2:0] {
    OP_PLUS, OP_MINUS, OP_DIM, OP_SHIFT0, OP_SHIFT1, OP_ENC_PLUS, OP_ENC_MINUS
  } cip_op_e;

  typedef enum logic [1:0] {ST_RUN, ST_CNT_RD, ST_CNT_WR, ST_ENTRY} cip_state_e;

  typedef struct packed {
    logic instrDone;
    logic resumeDone;
    logic irqInhibit;
    logic [PC_W-1:0] pc;
    logic [WORD_W-1:0] nextBuf;
  } cip_seq_in_s;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [CNT_AW-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } cip_prog_req_s;

  typedef struct packed {
    logic nextGo;
    logic busy;
    logic entryValid;
    logic [PC_W-1:0] vectorPc;
    logic [PC_W-1:0] savedPc;
    logic [WORD_W-1:0] savedBuf;
  } cip_seq_out_s;

  typedef struct packed {
    cip_state_e state;
    logic [2:0] phase;
    logic oscS1;
    logic oscS2;
    logic oscPrev;
    logic [CNT_NUM-1:0] upS1;
    logic [CNT_NUM-1:0] upS2;
    logic [CNT_NUM-1:0] upPrev;
    logic [CNT_NUM-1:0] dnS1;
    logic [CNT_NUM-1:0] dnS2;
    logic [CNT_NUM-1:0] dnPrev;
    logic [PIN_IRQ_NUM-1:0] rpS1;
    logic [PIN_IRQ_NUM-1:0] rpS2;
    logic [PIN_IRQ_NUM-1:0] rpPrev;
    logic [DIV_W-1:0] divCount;
    logic [PEND_W-1:0] cntPend;
    logic [IRQ_NUM-1:0] irqPend;
    logic irqActive;
    logic [PEND_IW-1:0] srvSel;
    logic [IRQ_IW-1:0] irqSel;
    logic entryValid;
    logic [PC_W-1:0] vectorPc;
    logic [PC_W-1:0] savedPc;
    logic [WORD_W-1:0] savedBuf;
  } cip_regs_s;

  localparam cip_regs_s REGS_RESET = '0;
endpackage : cip_pkg

//--- hw/cip_word_mem.sv
// erasable counter words with a registered read port
`timescale 1ns/1ns
module cip_word_mem (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic rdEn,
  input wire logic wrEn,
  input wire logic [cip_pkg::CNT_AW-1:0] addr,
  input wire logic [cip_pkg::WORD_W-1:0] wdata,
  output logic [cip_pkg::WORD_W-1:0] rdata
);
  logic [cip_pkg::WORD_W-1:0] words [cip_pkg::CNT_NUM];

  // no reset on the array: contents are program-loaded
  always_ff @(posedge core_clk) begin
    if (wrEn) begin
      words[addr] <= wdata;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= cip_pkg::WORD_RESET;
    end else if (rdEn) begin
      rdata <= words[addr];
    end
  end
endmodule : cip_word_mem

//--- tb/cip_pulse_source.sv
// pulse and oscillator source model facing the counter and interrupt pins
`timescale 1ns/1ns
module cip_pulse_source (
  input wire logic core_clk,
  output logic oscPin,
  output logic [cip_pkg::CNT_NUM-1:0] countUpPin,
  output logic [cip_pkg::CNT_NUM-1:0] countDownPin,
  output logic [cip_pkg::PIN_IRQ_NUM-1:0] irqPin
);
  initial begin
    oscPin = 1'b0;
    countUpPin = '0;
    countDownPin = '0;
    irqPin = '0;
  end

  // levels held three cycles each way, above the one-cycle minimum
  task automatic pulse(
    input logic [cip_pkg::CNT_NUM-1:0] up,
    input logic [cip_pkg::CNT_NUM-1:0] dn,
    input logic [cip_pkg::PIN_IRQ_NUM-1:0] rp
  );
    @(negedge core_clk);
    countUpPin = up;
    countDownPin = dn;
    irqPin = rp;
    repeat (3) @(negedge core_clk);
    countUpPin = '0;
    countDownPin = '0;
    irqPin = '0;
    repeat (3) @(negedge core_clk);
  endtask : pulse

  // 61 clocks a period is 488 ns; oscillator stands still between bursts
  task automatic oscEdges(input int n);
    repeat (n) begin
      @(negedge core_clk);
      oscPin = 1'b1;
      repeat (30) @(negedge core_clk);
      oscPin = 1'b0;
      repeat (30) @(negedge core_clk);
    end
  endtask : oscEdges
endmodule : cip_pulse_source

//--- tb/counter_and_interrupt_priority_test.sv
// self-checking bench of the counter and interrupt priority block
`timescale 1ns/1ns
module counter_and_interrupt_priority_test;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic oscPin;
  logic [cip_pkg::CNT_NUM-1:0] countUpPin;
  logic [cip_pkg::CNT_NUM-1:0] countDownPin;
  logic [cip_pkg::PIN_IRQ_NUM-1:0] irqPin;
  cip_pkg::cip_seq_in_s seqIn = '0;
  cip_pkg::cip_prog_req_s progReq = '0;
  cip_pkg::cip_seq_out_s seqOut;
  logic [cip_pkg::WORD_W-1:0] progRdata;
  logic evSeen;
  int failCount = 0;
  int totalChecks = 0;
  int n;
  int busyN;

  always #4 core_clk = ~core_clk;

  cip_pulse_source i_src (
    .core_clk(core_clk),
    .oscPin(oscPin),
    .countUpPin(countUpPin),
    .countDownPin(countDownPin),
    .irqPin(irqPin)
  );

  cip_counter_interrupt i_dut (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .oscPin(oscPin),
    .countUpPin(countUpPin),
    .countDownPin(countDownPin),
    .irqPin(irqPin),
    .seqIn(seqIn),
    .progReq(progReq),
    .seqOut(seqOut),
    .progRdata(progRdata)
  );

  task automatic conclude();
    $display("checks %0d mismatches %0d", totalChecks, failCount);
    if (failCount == 0 && totalChecks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude

  task automatic checkVal(input logic [15:0] got, input logic [15:0] exp);
    totalChecks++;
    if (got !== exp) begin
      failCount++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : checkVal

  task automatic checkClks(input int got, input int exp);
    totalChecks++;
    if (got != exp) begin
      failCount++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : checkClks

  // one instruction end; counts clocks until the next may start
  task automatic boundary(output int clks);
    @(negedge core_clk);
    seqIn.instrDone = 1'b1;
    clks = 0;
    busyN = 0;
    #1;
    while (seqOut.nextGo !== 1'b1 && clks < 200) begin
      @(negedge core_clk);
      seqIn.instrDone = 1'b0;
      clks++;
      #1;
      if (seqOut.busy === 1'b1) begin
        busyN++;
      end
    end
    evSeen = seqOut.entryValid;
    @(negedge core_clk);
    seqIn.instrDone = 1'b0;
  endtask : boundary

  task automatic resume();
    @(negedge core_clk);
    seqIn.resumeDone = 1'b1;
    @(negedge core_clk);
    seqIn.resumeDone = 1'b0;
  endtask : resume

  task automatic writeCtr(input logic [2:0] a, input logic [14:0] d);
    @(negedge core_clk);
    progReq.wr = 1'b1;
    progReq.addr = a;
    progReq.wdata = d;
    @(negedge core_clk);
    progReq.wr = 1'b0;
  endtask : writeCtr

  task automatic readCheck(input logic [2:0] a, input logic [14:0] exp);
    @(negedge core_clk);
    progReq.rd = 1'b1;
    progReq.addr = a;
    @(negedge core_clk);
    progReq.rd = 1'b0;
    checkVal(16'(progRdata), 16'(exp));
  endtask : readCheck

  task automatic testIdle();
    boundary(n);
    checkClks(n, 0);
    checkVal(16'(seqOut.busy), 16'h0000);
    checkVal(16'(evSeen), 16'h0000);
  endtask : testIdle

  // every step kind, the add and encoder steps at their wrap values, plus a chained overflow
  task automatic testSteps();
    writeCtr(3'h0, 15'h3FFF);
    writeCtr(3'h1, 15'h0005);
    writeCtr(3'h3, 15'h4000);
    writeCtr(3'h4, 15'h0003);
    writeCtr(3'h5, 15'h0001);
    writeCtr(3'h6, 15'h7FFF);
    writeCtr(3'h7, 15'h0000);
    i_src.pulse(8'h61, 8'h98, 2'h0);
    boundary(n);
    checkClks(n, 14);
    checkClks(busyN, 14);
    readCheck(3'h0, 15'h0000);
    readCheck(3'h1, 15'h0006);
    readCheck(3'h3, 15'h7FFF);
    readCheck(3'h4, 15'h0002);
    readCheck(3'h5, 15'h0003);
    readCheck(3'h6, 15'h0000);
    readCheck(3'h7, 15'h7FFF);
    i_src.pulse(8'h10, 8'h20, 2'h0);
    boundary(n);
    checkClks(n, 4);
    readCheck(3'h4, 15'h0001);
    readCheck(3'h5, 15'h0006);
  endtask : testSteps

  task automatic testEntry();
    seqIn.pc = 12'h123;
    seqIn.nextBuf = 15'h2AAA;
    i_src.pulse(8'h40, 8'h00, 2'h3);
    boundary(n);
    checkClks(n, 8);
    checkClks(busyN, 8);
    checkVal(16'(evSeen), 16'h0001);
    checkVal(16'(seqOut.vectorPc), 16'h0408);
    checkVal(16'(seqOut.savedPc), 16'h0123);
    checkVal(16'(seqOut.savedBuf), 16'h2AAA);
    boundary(n);
    checkClks(n, 0);
    resume();
    boundary(n);
    checkClks(n, 6);
    checkVal(16'(seqOut.vectorPc), 16'h040C);
    resume();
    readCheck(3'h6, 15'h0001);
  endtask : testEntry

  // timer overflow held back by the inhibit level, then taken
  task automatic testTimer();
    seqIn.irqInhibit = 1'b1;
    writeCtr(3'h2, 15'h3FFF);
    i_src.pulse(8'h04, 8'h00, 2'h0);
    boundary(n);
    checkClks(n, 2);
    seqIn.irqInhibit = 1'b0;
    boundary(n);
    checkClks(n, 6);
    checkVal(16'(seqOut.vectorPc), 16'h0400);
    resume();
    readCheck(3'h2, 15'h0000);
  endtask : testTimer

  // one edge short of the quantum must not step the time counter
  task automatic testTick();
    writeCtr(3'h0, 15'h0000);
    i_src.oscEdges(639);
    repeat (5) @(negedge core_clk);
    boundary(n);
    checkClks(n, 0);
    i_src.oscEdges(1);
    repeat (5) @(negedge core_clk);
    boundary(n);
    checkClks(n, 2);
    readCheck(3'h0, 15'h0001);
  endtask : testTick

  initial begin
    repeat (20) @(negedge core_clk);
    reset_n = 1'b1;
    repeat (4) @(negedge core_clk);
    testIdle();
    testSteps();
    testEntry();
    testTimer();
    testTick();
    conclude();
  end

  // the tick scenario alone takes about 312 us
  initial begin
    #600000;
    failCount++;
    conclude();
  end
endmodule : counter_and_interrupt_priority_test
